// ===== hdl/gpib_addr_pkg.sv
/*
  Constants, register layouts and state encodings for the address-status and address-mode
  block of a bus talker/listener/controller port.
  Assumes an 8-bit host register port, and command bytes that arrive already accepted
  from the acceptor handshake.
*/
package gpib_addr_pkg;

  // ------------------------------------------------------------------
  // host register offsets (port A and port B copies)
  // ------------------------------------------------------------------
  localparam logic [5:0] OFS_STATE_A = 6'h09;
  localparam logic [5:0] OFS_STATE_B = 6'h19;
  localparam logic [5:0] OFS_PASS_A  = 6'h0B;
  localparam logic [5:0] OFS_PASS_B  = 6'h1B;

  // ------------------------------------------------------------------
  // auxiliary command bytes written at the pass-through offset
  // ------------------------------------------------------------------
  localparam logic [7:0] AUX_PON_RELEASE = 8'h00;
  localparam logic [7:0] AUX_CHIP_RESET  = 8'h02;
  localparam logic [7:0] AUX_NON_VALID   = 8'h07;
  localparam logic [7:0] AUX_VALID       = 8'h0F;

  // ------------------------------------------------------------------
  // addressing modes and transceiver select codes
  // ------------------------------------------------------------------
  localparam logic [1:0] MODE_ALONE      = 2'h0;
  localparam logic [1:0] MODE_DUAL       = 2'h1;
  localparam logic [1:0] MODE_EXT_SINGLE = 2'h2;
  localparam logic [1:0] MODE_EXT_DUAL   = 2'h3;
  localparam logic [1:0] XCVR_EOI_PULSE_OUT   = 2'h0;
  localparam logic [1:0] XCVR_CIC_PULSE_OUT   = 2'h1;
  localparam logic [1:0] XCVR_CIC_EOI    = 2'h2;
  localparam logic [1:0] XCVR_CIC_PULLUP = 2'h3;
  localparam logic [7:0] MODE_REG_RESET  = 8'h00;
  localparam logic [7:0] PASS_RESET      = 8'h00;

  // ------------------------------------------------------------------
  // command byte decoding: bits 6..5 give the group, 4..0 the address
  // ------------------------------------------------------------------
  localparam logic [1:0] GRP_UNIVERSAL = 2'h0;
  localparam logic [1:0] GRP_LISTEN    = 2'h1;
  localparam logic [1:0] GRP_TALK      = 2'h2;
  localparam logic [1:0] GRP_SECONDARY = 2'h3;
  localparam logic [4:0] ADDR_NONE     = 5'h1F;
  localparam logic [6:0] CMD_GTL = 7'h01;
  localparam logic [6:0] CMD_SDC = 7'h04;
  localparam logic [6:0] CMD_PPC = 7'h05;
  localparam logic [6:0] CMD_GET = 7'h08;
  localparam logic [6:0] CMD_TCT = 7'h09;
  localparam logic [6:0] CMD_LLO = 7'h11;
  localparam logic [6:0] CMD_DCL = 7'h14;
  localparam logic [6:0] CMD_PPU = 7'h15;
  localparam logic [6:0] CMD_SPE = 7'h18;
  localparam logic [6:0] CMD_SPD = 7'h19;

  // disable bits in the second address register
  localparam int MINOR_SPEAK_OFF_BIT = 6;
  localparam int MINOR_HEAR_OFF_BIT  = 5;

  // ------------------------------------------------------------------
  // register layouts and state
  // ------------------------------------------------------------------
  typedef struct packed {
    logic       speak_alone;
    logic       hear_alone;
    logic       xcvr_sel_hi;
    logic       xcvr_sel_lo;
    logic [1:0] rsvd;
    logic       addr_mode_hi;
    logic       addr_mode_lo;
  } mode_reg_t;

  typedef struct packed {
    logic bus_master_flag;
    logic attention_level;
    logic poll_mode_flag;
    logic hear_primary_flag;
    logic speak_primary_flag;
    logic hearer_on_flag;
    logic speaker_on_flag;
    logic second_identity_flag;
  } addr_state_t;

  typedef struct packed {
    logic speaker;
    logic hearer;
    logic poll;
    logic hear_pri;
    logic speak_pri;
    logic ident;
    logic pend_ident;
    logic undecoded;
  } tl_state_t;

  typedef enum logic [2:0] {
    HOLD_NONE = 3'b001,
    HOLD_ADDR = 3'b010,
    HOLD_CMD  = 3'b100
  } hold_state_t;

endpackage : gpib_addr_pkg

// ===== hdl/sticky_event.sv
/*
  One sticky event bit: set by a hardware pulse, cleared by a read strobe.
  Assumes both inputs are synchronous to the system clock.
*/
`timescale 1ns/1ns
`default_nettype none
module sticky_event (
  input  wire logic i_clk_sys,
  input  wire logic i_sys_rst,
  input  wire logic i_set,
  input  wire logic i_clear,
  output logic      o_flag
);

  logic flag_d;
  logic flag_q;

  // set beats clear so an event in the clearing cycle survives
  always_comb begin
    flag_d = flag_q;
    if (i_clear) begin
      flag_d = 1'b0;
    end
    if (i_set) begin
      flag_d = 1'b1;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
    end
  end

  assign o_flag = flag_q;

endmodule : sticky_event
`default_nettype wire

// ===== hdl/gpib_address_status_mode.sv
/*
  Addressing part of a bus talker/listener/controller port: address status, address mode,
  pass-through byte, acceptor hold-off and transceiver pin steering.
  Assumes the acceptor handshake stalls while o_accept_hold is high, and that interrupt
  status registers live elsewhere and pulse their read strobes here.
*/
//
// How it works
// - bus master when controller neither idle nor addressed
// - attention flag mirrors the attention line level
// - poll flag sets on poll enable while talker
// - hear primary sets on own extended listen address
// - speak primary sets on own extended talk address
// - hearer flag shows addressed or active listener
// - listener addressing drops talker, and vice versa
// - speaker flag shows addressed, active or poll talker
// - second identity flags minor address, modes 1/3
// - speak alone sets talker; clearing bit alone insufficient
// - hear alone sets listener; clearing bit alone insufficient
// - transceiver select steers the two pin outputs
// - mode field picks alone, dual, extended single, dual
// - mode 1 answers major and minor primary addresses
// - minor talker and listener can be disabled
// - mode 2 needs primary then secondary address
// - mode 3 secondary held for host verdict
// - undecoded commands pass through, handshake held
// - valid and non-valid commands release the hold
// - status change event on speaker, hearer, bus master, identity changes, not alone
// - chip reset idles functions; pon release frees them
`timescale 1ns/1ns
`default_nettype none
module gpib_address_status_mode
  import gpib_addr_pkg::*;
(
  input  wire logic  i_clk_sys,
  input  wire logic  i_sys_rst,
  input  wire logic  [5:0] i_host_addr,
  input  wire logic  i_host_wr,
  input  wire logic  i_host_rd,
  input  wire logic  [7:0] i_host_wdata,
  output logic       [7:0] o_host_rdata,
  input  wire logic  i_isr1_read,
  input  wire logic  i_int_state_reg_two_read,
  input  wire logic  i_passthru_en,
  input  wire logic  [7:0] i_first_addr,
  input  wire logic  [7:0] i_second_addr,
  input  wire logic  i_atn_n,
  input  wire logic  i_ctrl_idle,
  input  wire logic  i_ctrl_addressed,
  input  wire logic  i_cmd_valid,
  input  wire logic  [7:0] i_cmd_byte,
  input  wire logic  i_end_line_drive_on,
  input  wire logic  i_pulse_out,
  input  wire logic  i_pullup_on,
  output logic       o_accept_hold,
  output addr_state_t o_addr_state,
  output mode_reg_t  o_addr_mode,
  output logic       o_second_addr_event,
  output logic       o_passthru_event,
  output logic       o_addr_change_event,
  output logic       o_xcvr_out_two,
  output logic       o_xcvr_out_three
);

  // ------------------------------------------------------------------
  // host decode
  // ------------------------------------------------------------------
  logic at_state;
  logic at_pass;
  logic mode_wr;
  logic aux_wr;
  logic aux_pon;
  logic aux_reset;
  logic aux_valid;
  logic aux_nonvalid;

  // one offset, two registers: reads see status, writes load mode
  assign at_state     = (i_host_addr == OFS_STATE_A) || (i_host_addr == OFS_STATE_B);
  assign at_pass      = (i_host_addr == OFS_PASS_A) || (i_host_addr == OFS_PASS_B);
  assign mode_wr      = i_host_wr && at_state;
  assign aux_wr       = i_host_wr && at_pass;
  assign aux_pon      = aux_wr && (i_host_wdata == AUX_PON_RELEASE);
  assign aux_reset    = aux_wr && (i_host_wdata == AUX_CHIP_RESET);
  assign aux_valid    = aux_wr && (i_host_wdata == AUX_VALID);
  assign aux_nonvalid = aux_wr && (i_host_wdata == AUX_NON_VALID);

  // ------------------------------------------------------------------
  // talker / listener state
  // ------------------------------------------------------------------
  mode_reg_t   mode_d;
  mode_reg_t   mode_q;
  tl_state_t   tl_d;
  tl_state_t   tl_q;
  hold_state_t hold_d;
  hold_state_t hold_q;
  logic        pon_d;
  logic        pon_q;
  logic [7:0]  pass_d;
  logic [7:0]  pass_q;
  logic        addr_set;
  logic        cmd_set;
  logic        cmd_take;
  logic [1:0]  amode;
  logic [1:0]  grp;
  logic [4:0]  adr;
  logic        ext;
  logic        hear_maj;
  logic        hear_min;
  logic        speak_maj;
  logic        speak_min;
  logic        known_cmd;
  logic        bus_master;

  assign amode      = {mode_q.addr_mode_hi, mode_q.addr_mode_lo};
  assign ext        = mode_q.addr_mode_hi;
  assign grp        = i_cmd_byte[6:5];
  assign adr        = i_cmd_byte[4:0];
  assign bus_master = !(i_ctrl_idle || i_ctrl_addressed);
  // commands only land while free of a hold and of the pon hold
  assign cmd_take   = i_cmd_valid && (hold_q == HOLD_NONE) && !pon_q;

  // minor identity only in the dual modes, each half can be switched off
  assign hear_maj  = (adr == i_first_addr[4:0]);
  assign speak_maj = (adr == i_first_addr[4:0]);
  assign hear_min  = mode_q.addr_mode_lo && (adr == i_second_addr[4:0])
                     && !i_second_addr[MINOR_HEAR_OFF_BIT];
  assign speak_min = mode_q.addr_mode_lo && (adr == i_second_addr[4:0])
                     && !i_second_addr[MINOR_SPEAK_OFF_BIT];

  always_comb begin
    case (i_cmd_byte[6:0])
      CMD_GTL, CMD_SDC, CMD_PPC, CMD_GET, CMD_TCT,
      CMD_LLO, CMD_DCL, CMD_PPU, CMD_SPE, CMD_SPD: known_cmd = 1'b1;
      default: known_cmd = 1'b0;
    endcase
  end

  // next state of the whole addressing group
  always_comb begin
    tl_d     = tl_q;
    hold_d   = hold_q;
    pon_d    = pon_q;
    mode_d   = mode_q;
    pass_d   = pass_q;
    addr_set = 1'b0;
    cmd_set  = 1'b0;
    if (mode_wr) begin
      mode_d = mode_reg_t'(i_host_wdata);
    end
    if (aux_pon) begin
      pon_d = 1'b0;
    end
    if (cmd_take) begin
      // primary bytes end any extended or undecoded sequence in progress
      if (grp != GRP_SECONDARY) begin
        tl_d.hear_pri  = ext && (grp == GRP_LISTEN) && (adr != ADDR_NONE)
                         && (hear_maj || hear_min);
        tl_d.speak_pri = ext && (grp == GRP_TALK) && (adr != ADDR_NONE)
                         && (speak_maj || speak_min);
        tl_d.pend_ident = (grp == GRP_LISTEN) ? (hear_min && !hear_maj)
                                              : (speak_min && !speak_maj);
        tl_d.undecoded = (grp == GRP_UNIVERSAL) && i_passthru_en && !known_cmd;
      end
      case (grp)
        GRP_UNIVERSAL: begin
          if ((i_cmd_byte[6:0] == CMD_SPE) && tl_q.speaker) begin
            tl_d.poll = 1'b1;
          end
          if (i_cmd_byte[6:0] == CMD_SPD) begin
            tl_d.poll = 1'b0;
          end
          if (i_passthru_en && !known_cmd) begin
            pass_d  = i_cmd_byte;
            cmd_set = 1'b1;
            hold_d  = HOLD_CMD;
          end
        end
        GRP_LISTEN: begin
          // mode 0 ignores bus addressing, unlisten included
          if ((adr == ADDR_NONE) && (amode != MODE_ALONE)) begin
            tl_d.hearer = 1'b0;
          end else if ((amode == MODE_DUAL) && (hear_maj || hear_min)) begin
            tl_d.hearer  = 1'b1;
            tl_d.speaker = 1'b0;
            tl_d.ident   = hear_min && !hear_maj;
          end
        end
        GRP_TALK: begin
          if ((adr == ADDR_NONE) && (amode != MODE_ALONE)) begin
            tl_d.speaker = 1'b0;
          end else if (amode == MODE_DUAL) begin
            if (speak_maj || speak_min) begin
              tl_d.speaker = 1'b1;
              tl_d.hearer  = 1'b0;
              tl_d.ident   = speak_min && !speak_maj;
            end else begin
              tl_d.speaker = 1'b0; // another talker took the bus
            end
          end
        end
        GRP_SECONDARY: begin
          if (tl_q.undecoded) begin
            pass_d  = i_cmd_byte;
            cmd_set = 1'b1;
            hold_d  = HOLD_CMD;
          end else if ((amode == MODE_EXT_SINGLE) && (adr == i_second_addr[4:0])) begin
            // mode 2 completes in hardware, no host verdict needed
            if (tl_q.hear_pri) begin
              tl_d.hearer  = 1'b1;
              tl_d.speaker = 1'b0;
            end
            if (tl_q.speak_pri) begin
              tl_d.speaker = 1'b1;
              tl_d.hearer  = 1'b0;
            end
          end else if ((amode == MODE_EXT_DUAL) && (tl_q.hear_pri || tl_q.speak_pri)) begin
            pass_d   = i_cmd_byte;
            addr_set = 1'b1;
            hold_d   = HOLD_ADDR;
          end
        end
        default: begin
          tl_d = tl_q;
        end
      endcase
    end
    // host verdict releases the held byte; only valid on an address applies it
    if ((hold_q != HOLD_NONE) && (aux_valid || aux_nonvalid)) begin
      hold_d = HOLD_NONE;
      if ((hold_q == HOLD_ADDR) && aux_valid) begin
        if (tl_q.hear_pri) begin
          tl_d.hearer  = 1'b1;
          tl_d.speaker = 1'b0;
          tl_d.ident   = tl_q.pend_ident;
        end
        if (tl_q.speak_pri) begin
          tl_d.speaker = 1'b1;
          tl_d.hearer  = 1'b0;
          tl_d.ident   = tl_q.pend_ident;
        end
      end
    end
    // alone bits only set roles; clearing them leaves the role standing
    if (!pon_q && mode_q.speak_alone) begin
      tl_d.speaker = 1'b1;
    end
    if (!pon_q && mode_q.hear_alone) begin
      tl_d.hearer = 1'b1;
    end
    // the pon hold keeps every function idle until released
    if (pon_q || aux_reset) begin
      tl_d   = '0;
      hold_d = HOLD_NONE;
    end
    if (aux_reset) begin
      pon_d              = 1'b1;
      mode_d.xcvr_sel_hi = 1'b0;
      mode_d.xcvr_sel_lo = 1'b0;
    end
  end

  // power-up starts in the pon hold, as after a chip reset
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      tl_q   <= '0;
      hold_q <= HOLD_NONE;
      pon_q  <= 1'b1;
      mode_q <= mode_reg_t'(MODE_REG_RESET);
      pass_q <= PASS_RESET;
    end else begin
      tl_q   <= tl_d;
      hold_q <= hold_d;
      pon_q  <= pon_d;
      mode_q <= mode_d;
      pass_q <= pass_d;
    end
  end

  // ------------------------------------------------------------------
  // status view and events
  // ------------------------------------------------------------------
  addr_state_t state_v;
  logic [3:0]  watch_d;
  logic [3:0]  watch_q;
  logic        change_set;

  always_comb begin
    state_v.bus_master_flag      = bus_master;
    state_v.attention_level      = i_atn_n;
    state_v.poll_mode_flag       = tl_q.poll;
    state_v.hear_primary_flag    = tl_q.hear_pri;
    state_v.speak_primary_flag   = tl_q.speak_pri;
    state_v.hearer_on_flag       = tl_q.hearer;
    state_v.speaker_on_flag      = tl_q.speaker;
    state_v.second_identity_flag = tl_q.ident && mode_q.addr_mode_lo;
  end

  assign watch_d = {state_v.speaker_on_flag, state_v.hearer_on_flag,
                    state_v.bus_master_flag, state_v.second_identity_flag};
  // alone modes change roles by software, so they stay silent
  assign change_set = (watch_d != watch_q)
                      && !(mode_q.speak_alone || mode_q.hear_alone);

  // read data registered one cycle after the strobe
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      watch_q      <= 4'h0;
      o_host_rdata <= 8'h00;
    end else begin
      watch_q <= watch_d;
      if (i_host_rd && at_state) begin
        o_host_rdata <= state_v;
      end else if (i_host_rd && at_pass) begin
        o_host_rdata <= pass_q;
      end else if (i_host_rd) begin
        o_host_rdata <= 8'h00;
      end
    end
  end

  sticky_event u_change_event (
    .i_clk_sys (i_clk_sys),
    .i_sys_rst (i_sys_rst),
    .i_set     (change_set),
    .i_clear   (i_int_state_reg_two_read),
    .o_flag    (o_addr_change_event)
  );

  sticky_event u_addr_event (
    .i_clk_sys (i_clk_sys),
    .i_sys_rst (i_sys_rst),
    .i_set     (addr_set),
    .i_clear   (i_isr1_read),
    .o_flag    (o_second_addr_event)
  );

  sticky_event u_pass_event (
    .i_clk_sys (i_clk_sys),
    .i_sys_rst (i_sys_rst),
    .i_set     (cmd_set),
    .i_clear   (i_isr1_read),
    .o_flag    (o_passthru_event)
  );

  // ------------------------------------------------------------------
  // pin steering and outputs
  // ------------------------------------------------------------------
  always_comb begin
    case ({mode_q.xcvr_sel_hi, mode_q.xcvr_sel_lo})
      XCVR_EOI_PULSE_OUT: begin
        o_xcvr_out_two   = i_end_line_drive_on;
        o_xcvr_out_three = i_pulse_out;
      end
      XCVR_CIC_PULSE_OUT: begin
        o_xcvr_out_two   = bus_master;
        o_xcvr_out_three = i_pulse_out;
      end
      XCVR_CIC_EOI: begin
        o_xcvr_out_two   = bus_master;
        o_xcvr_out_three = i_end_line_drive_on;
      end
      default: begin // board expects this code
        o_xcvr_out_two   = bus_master;
        o_xcvr_out_three = i_pullup_on;
      end
    endcase
  end

  assign o_accept_hold = (hold_q != HOLD_NONE);
  assign o_addr_state  = state_v;
  assign o_addr_mode   = mode_q;

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);

  chk_bus_master_read: assert property (
    (i_host_rd && at_state) |=> (o_host_rdata[7] == $past(bus_master)))
    else $error("bus master bit read wrong");
  chk_attention_read: assert property (
    (i_host_rd && at_state) |=> (o_host_rdata[6] == $past(i_atn_n)))
    else $error("attention bit read wrong");
  chk_poll_enable: assert property (
    (cmd_take && (i_cmd_byte[6:0] == CMD_SPE) && tl_q.speaker && !aux_reset)
    |=> o_addr_state.poll_mode_flag)
    else $error("poll flag not set");
  chk_hear_primary_reset: assert property (
    aux_reset |=> !o_addr_state.hear_primary_flag [*2])
    else $error("hear primary survived chip reset");
  chk_listen_drops_talk: assert property (
    (cmd_take && (amode == MODE_DUAL) && (grp == GRP_LISTEN) && (adr != ADDR_NONE)
     && hear_maj && !aux_reset && !mode_q.speak_alone)
    |=> (o_addr_state.hearer_on_flag && !o_addr_state.speaker_on_flag))
    else $error("listen address kept talker");
  chk_alone_sticky: assert property (
    (o_addr_state.speaker_on_flag && (amode == MODE_ALONE) && !aux_reset && !pon_q)
    |=> o_addr_state.speaker_on_flag)
    else $error("talker left without reset");
  chk_ident_modes: assert property (
    !mode_q.addr_mode_lo |-> !o_addr_state.second_identity_flag)
    else $error("identity flag outside dual modes");
  chk_xcvr_pullup: assert property (
    ({mode_q.xcvr_sel_hi, mode_q.xcvr_sel_lo} == XCVR_CIC_PULLUP)
    |-> (o_xcvr_out_two == !(i_ctrl_idle || i_ctrl_addressed)
         && o_xcvr_out_three == i_pullup_on))
    else $error("pin steering wrong");
  chk_hold_until_verdict: assert property (
    (o_accept_hold && !aux_valid && !aux_nonvalid && !aux_reset) |=> o_accept_hold)
    else $error("hold released without verdict");
  chk_reset_xcvr: assert property (
    aux_reset |=> (!mode_q.xcvr_sel_hi && !mode_q.xcvr_sel_lo && pon_q))
    else $error("chip reset left transceiver bits");
  chk_change_event: assert property (
    ($changed(o_addr_state.hearer_on_flag) && !mode_q.hear_alone
     && !mode_q.speak_alone) |=> o_addr_change_event)
    else $error("status change not flagged");

endmodule : gpib_address_status_mode
`default_nettype wire

// ===== verification/bus_ctrl_model.sv
/*
  Bus controller model: sends command bytes to the block under attention.
  Assumes the block raises i_accept_hold while a byte waits for the host.
*/
`timescale 1ns/1ns
`default_nettype none
module bus_ctrl_model (
  input  wire logic       i_clk_sys,
  input  wire logic       i_accept_hold,
  output logic            o_cmd_valid,
  output logic      [7:0] o_cmd_byte,
  output logic            o_atn_n
);
  initial begin
    o_cmd_valid = 1'b0;
    o_cmd_byte  = 8'hFF;
    o_atn_n     = 1'b1;
  end
  // wait out a hold of up to 50 cycles first, since a byte sent into a hold is dropped
  task automatic send(input logic [7:0] b);
    int n;
    n = 0;
    while (i_accept_hold !== 1'b0 && n < 50) begin
      @(posedge i_clk_sys);
      n++;
    end
    @(posedge i_clk_sys);
    o_atn_n     <= 1'b0;
    o_cmd_valid <= 1'b1;
    o_cmd_byte  <= b;
    @(posedge i_clk_sys);
    o_cmd_valid <= 1'b0;
    o_cmd_byte  <= ~b; // released lines show no stale byte
    @(posedge i_clk_sys);
    o_atn_n     <= 1'b1;
    @(posedge i_clk_sys);
  endtask : send
endmodule : bus_ctrl_model
`default_nettype wire

// ===== verification/gpib_address_status_mode_tb.sv
/*
  Self-checking bench for the address status and mode block.
  Assumes bus_ctrl_model stands in for the bus controller.
*/
`timescale 1ns/1ns
`default_nettype none
module gpib_address_status_mode_tb;
  import gpib_addr_pkg::*;
  typedef struct packed {logic [7:0] mode; logic two; logic three;} row_t;
  logic        clk, rst, wr, rd, idle, adr, int_state_reg_two, hold, ev2, evs, two, three, cv, atn;
  logic        isr1, pte, eol, pls, pue, pev;
  logic [5:0]  addr;
  logic [7:0]  wd, rdata, cb, sa, r;
  addr_state_t st;
  mode_reg_t   md;
  int          checks, bad_count, cyc;
  // pins with end-line 0, pulse 1, pull-up 0 and bus master 1
  row_t rows [4] = '{'{8'h00, 1'b0, 1'b1}, '{8'h11, 1'b1, 1'b1},
                     '{8'h22, 1'b1, 1'b0}, '{8'h33, 1'b1, 1'b0}};
  gpib_address_status_mode dut_u (.i_clk_sys(clk), .i_sys_rst(rst), .i_host_addr(addr),
    .i_host_wr(wr), .i_host_rd(rd), .i_host_wdata(wd), .o_host_rdata(rdata),
    .i_isr1_read(isr1), .i_int_state_reg_two_read(int_state_reg_two), .i_passthru_en(pte), .i_first_addr(8'h05),
    .i_second_addr(sa), .i_atn_n(atn), .i_ctrl_idle(idle), .i_ctrl_addressed(adr),
    .i_cmd_valid(cv), .i_cmd_byte(cb), .i_end_line_drive_on(eol), .i_pulse_out(pls),
    .i_pullup_on(pue), .o_accept_hold(hold), .o_addr_state(st), .o_addr_mode(md),
    .o_second_addr_event(evs), .o_passthru_event(pev), .o_addr_change_event(ev2),
    .o_xcvr_out_two(two), .o_xcvr_out_three(three));
  bus_ctrl_model bus_u (.i_clk_sys(clk), .i_accept_hold(hold), .o_cmd_valid(cv),
    .o_cmd_byte(cb), .o_atn_n(atn));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic hw(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wd   <= d;
    wr   <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask : hw
  task automatic hr(input logic [5:0] a);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 r = rdata;
  endtask : hr
  task automatic finish_test;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : finish_test
  // hang guard: the whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      finish_test();
    end
  end
  initial begin
    {rst, wr, rd, int_state_reg_two, adr, idle, addr, wd, sa} = {1'b1, 5'h01, 6'h00, 8'h00, 8'h06};
    {isr1, pte, eol, pls, pue} = 5'h02;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    hr(OFS_STATE_A);
    chk("status", 8'h40, r);
    idle <= 1'b0;
    foreach (rows[i]) begin
      hw(OFS_STATE_B, rows[i].mode);
      chk("mode", rows[i].mode, md);
      chk("pins", {6'h00, rows[i].two, rows[i].three}, {6'h00, two, three});
    end
    hr(OFS_STATE_B);
    chk("status", 8'hC0, r);
    adr <= 1'b1;
    hr(OFS_STATE_A);
    chk("status", 8'h40, r);
    {idle, adr} <= 2'b10;
    $display("reset and table done");
    hw(OFS_PASS_A, AUX_PON_RELEASE);
    hw(OFS_STATE_A, 8'h31);
    // clear events left by the controller-state steps so the next one is fresh
    int_state_reg_two <= 1'b1;
    @(posedge clk) int_state_reg_two <= 1'b0;
    bus_u.send(8'h25);
    hr(OFS_STATE_A);
    chk("status", 8'h44, r);
    chk("change", 8'h01, {7'h00, ev2});
    int_state_reg_two <= 1'b1;
    @(posedge clk) int_state_reg_two <= 1'b0;
    @(posedge clk) chk("change", 8'h00, {7'h00, ev2});
    bus_u.send(8'h46);
    hr(OFS_STATE_A);
    chk("status", 8'h43, r);
    bus_u.send(8'h18);
    hr(OFS_STATE_A);
    chk("status", 8'h63, r);
    bus_u.send(8'h19);
    hr(OFS_STATE_A);
    chk("status", 8'h43, r);
    sa <= 8'h66;
    bus_u.send(8'h5F);
    bus_u.send(8'h46);
    chk("speaker", 8'h00, {7'h00, st.speaker_on_flag});
    hw(OFS_PASS_B, AUX_CHIP_RESET);
    chk("xcvr", 8'h00, {6'h00, md.xcvr_sel_hi, md.xcvr_sel_lo});
    hr(OFS_STATE_A);
    chk("status", 8'h40, r);
    $display("dual addressing done");
    hw(OFS_PASS_A, AUX_PON_RELEASE);
    hw(OFS_STATE_A, 8'h33);
    bus_u.send(8'h25);
    chk("hear_pri", 8'h01, {7'h00, st.hear_primary_flag});
    bus_u.send(8'h65);
    chk("hold", 8'h03, {6'h00, hold, evs});
    hr(OFS_PASS_A);
    chk("passthru", 8'h65, r);
    hw(OFS_PASS_A, AUX_VALID);
    chk("hold_hear", 8'h01, {6'h00, hold, st.hearer_on_flag});
    bus_u.send(8'h45);
    chk("speak_pri", 8'h01, {7'h00, st.speak_primary_flag});
    bus_u.send(8'h65);
    hw(OFS_PASS_B, AUX_NON_VALID);
    chk("hold_spk", 8'h00, {6'h00, hold, st.speaker_on_flag});
    // mode 2 completes talk addressing in hardware, no hold
    hw(OFS_STATE_A, 8'h32);
    bus_u.send(8'h45);
    bus_u.send(8'h66);
    chk("ext_single", 8'h02, {5'h00, hold, st.speaker_on_flag, st.hearer_on_flag});
    // undecoded command and its secondary pass through to the host
    {pte, isr1} <= 2'b11;
    @(posedge clk) isr1 <= 1'b0;
    bus_u.send(8'h1E);
    chk("pass_hold", 8'h06, {5'h00, hold, pev, evs});
    hw(OFS_PASS_A, AUX_VALID);
    bus_u.send(8'h61);
    hr(OFS_PASS_B);
    chk("passthru", 8'h61, r);
    hw(OFS_PASS_A, AUX_VALID);
    chk("pass_free", 8'h00, {7'h00, hold});
    $display("extended addressing done");
    hw(OFS_PASS_A, AUX_CHIP_RESET);
    hw(OFS_PASS_A, AUX_PON_RELEASE);
    hw(OFS_STATE_A, 8'h80);
    hw(OFS_STATE_A, 8'h00);
    chk("speaker", 8'h01, {7'h00, st.speaker_on_flag});
    hw(OFS_STATE_A, 8'h40);
    hw(OFS_STATE_A, 8'h00);
    chk("hearer", 8'h01, {7'h00, st.hearer_on_flag});
    // power-on reset mid-run is the other way out of the alone roles
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    hr(OFS_STATE_A);
    chk("status", 8'h40, r);
    chk("mode", 8'h00, md);
    $display("alone modes done");
    finish_test();
  end
endmodule : gpib_address_status_mode_tb
`default_nettype wire
